/* core/ufc_map.svh */
/*
 * register map, field positions, reset values and fill levels of the uart flow-control core.
 * assumes: included by bare name; 32-bit classic wishbone words, data in the low byte.
 */
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH
`define UFC_ADR_EFR 8'h00
`define UFC_ADR_RES1 8'h04
`define UFC_ADR_RES2 8'h08
`define UFC_ADR_STP1 8'h0c
`define UFC_ADR_STP2 8'h10
`define UFC_ADR_IER 8'h14
`define UFC_ADR_ISR 8'h18
`define UFC_ADR_FCR 8'h1c
`define UFC_ADR_MCR 8'h20
`define UFC_ADR_DLD 8'h24
`define UFC_ADR_DLL 8'h28
`define UFC_ADR_DLM 8'h2c
`define UFC_ADR_STAT 8'h30
`define UFC_RST_BYTE 8'h00
`define UFC_DLL_PWRUP 8'h01
`define UFC_DLM_PWRUP 8'h00
`define UFC_ENH_MASK_IER 8'hf0
`define UFC_ENH_MASK_FCR 8'h38
`define UFC_ENH_MASK_MCR 8'he0
`define UFC_EFR_ENH 4
`define UFC_EFR_SPEC 5
`define UFC_EFR_ARTS 6
`define UFC_EFR_ACTS 7
`define UFC_EFR_RX 1:0
`define UFC_EFR_TX 3:2
`define UFC_FCR_TRIG 7:6
`define UFC_IER_ENH 7:4
`define UFC_DLD_SEL 7:6
`define UFC_DLD_RXRD 7
`define UFC_DLD_FRAC 5:0
`define UFC_DLD_BOTH 2'b00
`define UFC_DLD_NONE 2'b10
`define UFC_DLD_RXONLY 2'b11
`define UFC_SEL_NONE 2'b00
`define UFC_SEL_FIRST 2'b10
`define UFC_SEL_SECOND 2'b01
`define UFC_SEL_BOTH 2'b11
`define UFC_MCR_DTR 0
`define UFC_MCR_RTS 1
`define UFC_MCR_INTEN 3
`define UFC_IER_RXDATA 0
`define UFC_IER_STOP 5
`define UFC_IER_RTS 6
`define UFC_IER_CTS 7
`define UFC_LVL_0 6'd8
`define UFC_LVL_1 6'd16
`define UFC_LVL_2 6'd24
`define UFC_LVL_3 6'd28
`define UFC_LVL_TOP 6'd30
`define UFC_LVL_BOT 6'd4
`endif

/* core/ufc_pkg.sv */
/*
 * types of the uart flow-control core.
 * assumes: compiled before ufc_core.
 */
package ufc_pkg;
    typedef enum logic [2:0] {
        UFC_FC_IDLE = 3'b001,
        UFC_FC_FIRST = 3'b010,
        UFC_FC_SECOND = 3'b100
    } ufc_fc_state_t;
endpackage : ufc_pkg

/* core/ufc_core.sv */
/*
 * uart flow-control core: enhanced feature register, software and hardware
 * flow control, special character detect, enhanced-bit lock and reset states.
 * assumes: a receiver presents each character for one cycle, a fifo counter
 * gives the receive fill level, a transmitter serialises data and takes flow
 * characters by valid/ready; all inputs are synchronous to clk.
 */
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "ufc_map.svh"
module ufc_core
    import ufc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic [5:0] rx_level,
    output logic rx_store,
    output logic [7:0] rx_store_data,
    input wire logic cts_n,
    output logic tx_halt,
    output logic fc_valid,
    input wire logic fc_ready,
    output logic [7:0] fc_data,
    input wire logic txd_raw,
    output logic txd_o,
    output logic rts_n,
    output logic dtr_n,
    output logic int_o,
    output logic int_oe_n,
    output logic [7:0] addr_match_char,
    output logic [15:0] tx_divisor,
    output logic [15:0] rx_divisor,
    output logic [5:0] frac_cfg
);
    logic [7:0] efr_q, efr_d, ier_q, ier_d, fcr_q, fcr_d, mcr_q, mcr_d, dld_q, dld_d;
    logic [7:0] resume_char_first_q, resume_char_first_d;
    logic [7:0] resume_char_second_q, resume_char_second_d;
    logic [7:0] stop_char_first_q, stop_char_first_d;
    logic [7:0] stop_char_second_q, stop_char_second_d;
    // divisors carry no reset: they keep their value across sys_rst
    logic [7:0] tx_dll_q = `UFC_DLL_PWRUP;
    logic [7:0] tx_dlm_q = `UFC_DLM_PWRUP;
    logic [7:0] rx_dll_q = `UFC_DLL_PWRUP;
    logic [7:0] rx_dlm_q = `UFC_DLM_PWRUP;
    logic [7:0] tx_dll_d, tx_dlm_d, rx_dll_d, rx_dlm_d;
    logic stop_flag_q, stop_flag_d, hw_flag_q, hw_flag_d;
    logic sw_halt_q, sw_halt_d, prev_stop1_q, prev_stop1_d, prev_res1_q, prev_res1_d;
    logic rts_block_q, rts_block_d, prev_cts_q, prev_cts_d;
    logic rx_store_q, rx_store_d;
    logic [7:0] rx_store_data_q, rx_store_data_d;
    ufc_fc_state_t fc_state_q, fc_state_d;
    logic stop_sent_q, stop_sent_d, send_stop_q, send_stop_d;
    logic [7:0] fc_data_q, fc_data_d;
    logic tx_halt_q, tx_halt_d, txd_q, txd_d, rts_n_q, rts_n_d, dtr_n_q, dtr_n_d;
    logic int_q, int_d, int_oe_n_q, int_oe_n_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic wr_fire, rd_fire, dl_tx_wr, dl_rx_wr;
    logic [1:0] rx_sel, tx_sel;
    logic mode_either, mode_seq, enh;
    logic [3:0] hit;
    logic stop_now, resume_now, special, trig_hit, below_low, above_up;
    logic [5:0] lvl_trig, lvl_up, lvl_low;

    // hit[0..3]: first resume, second resume, first stop, second stop
    wire [7:0] cmp_char [4] = '{resume_char_first_q, resume_char_second_q,
                                 stop_char_first_q, stop_char_second_q};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign hit[gi] = (rx_data == cmp_char[gi]);
        end
    endgenerate

    // bus strobes: ack one cycle after request, effects at the ack edge
    assign wr_fire = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    assign rd_fire = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;
    assign enh = efr_q[`UFC_EFR_ENH];
    assign rx_sel = efr_q[`UFC_EFR_RX];
    assign tx_sel = efr_q[`UFC_EFR_TX];
    // divisor write targets: both, transmit only, none, receive only
    assign dl_tx_wr = dld_q[`UFC_DLD_SEL] != `UFC_DLD_RXONLY &&
        dld_q[`UFC_DLD_SEL] != `UFC_DLD_NONE;
    assign dl_rx_wr = dld_q[`UFC_DLD_SEL] == `UFC_DLD_BOTH ||
        dld_q[`UFC_DLD_SEL] == `UFC_DLD_RXONLY;
    assign mode_either = (rx_sel == `UFC_SEL_BOTH) &&
        (tx_sel == `UFC_SEL_FIRST || tx_sel == `UFC_SEL_SECOND);
    assign mode_seq = (rx_sel == `UFC_SEL_BOTH) &&
        (tx_sel == `UFC_SEL_BOTH || tx_sel == `UFC_SEL_NONE);

    always_comb begin
        case (fcr_q[`UFC_FCR_TRIG])
            2'b00: begin lvl_trig = `UFC_LVL_0; lvl_up = `UFC_LVL_1; lvl_low = `UFC_LVL_BOT; end
            2'b01: begin lvl_trig = `UFC_LVL_1; lvl_up = `UFC_LVL_2; lvl_low = `UFC_LVL_0; end
            2'b10: begin lvl_trig = `UFC_LVL_2; lvl_up = `UFC_LVL_3; lvl_low = `UFC_LVL_1; end
            default: begin lvl_trig = `UFC_LVL_3; lvl_up = `UFC_LVL_TOP; lvl_low = `UFC_LVL_2; end
        endcase
    end
    assign trig_hit = rx_level >= lvl_trig;
    assign above_up = rx_level >= lvl_up;
    assign below_low = rx_level < lvl_low;

    // receive compare
    always_comb begin
        stop_now = 1'b0;
        resume_now = 1'b0;
        if (rx_valid) begin
            if (rx_sel == `UFC_SEL_FIRST) begin
                stop_now = hit[2];
                resume_now = hit[0];
            end else if (rx_sel == `UFC_SEL_SECOND) begin
                stop_now = hit[3];
                resume_now = hit[1];
            end else if (mode_either) begin
                stop_now = hit[2] || hit[3];
                resume_now = hit[0] || hit[1];
            end else if (mode_seq) begin
                stop_now = prev_stop1_q && hit[3];
                resume_now = prev_res1_q && hit[1];
            end
        end
    end
    assign special = rx_valid && efr_q[`UFC_EFR_SPEC] && hit[3];

    always_comb begin
        prev_stop1_d = prev_stop1_q;
        prev_res1_d = prev_res1_q;
        // in sequence mode the first character has already gone to the fifo;
        // only the completing second character is withheld
        if (rx_valid) begin
            prev_stop1_d = mode_seq && hit[2];
            prev_res1_d = mode_seq && hit[0];
        end
        // flow characters, except the first of a sequence pair, never enter the fifo; a special match under
        // first-pair compare is not a flow character and is stored
        rx_store_d = rx_valid && !stop_now && !resume_now;
        rx_store_data_d = rx_valid ? rx_data : rx_store_data_q;
        sw_halt_d = sw_halt_q;
        if (rx_sel == `UFC_SEL_NONE)
            sw_halt_d = 1'b0;
        else if (stop_now)
            sw_halt_d = 1'b1;
        else if (resume_now)
            sw_halt_d = 1'b0;
        rts_block_d = rts_block_q ? !below_low : above_up;
        prev_cts_d = cts_n;
    end

    // status flags: a set in the same cycle as a clear wins; held while locked
    always_comb begin
        stop_flag_d = stop_flag_q;
        hw_flag_d = hw_flag_q;
        if (enh) begin
            if (rd_fire && wb_adr_i == `UFC_ADR_ISR)
                stop_flag_d = 1'b0;
            if (resume_now)
                stop_flag_d = 1'b0;
            if (stop_now || special)
                stop_flag_d = 1'b1;
            if (rd_fire && wb_adr_i == `UFC_ADR_ISR)
                hw_flag_d = 1'b0;
            if ((efr_q[`UFC_EFR_ARTS] && rts_block_d != rts_block_q) ||
                (efr_q[`UFC_EFR_ACTS] && cts_n != prev_cts_q))
                hw_flag_d = 1'b1;
        end
    end

    // flow character sender
    always_comb begin
        fc_state_d = fc_state_q;
        stop_sent_d = stop_sent_q;
        send_stop_d = send_stop_q;
        fc_data_d = fc_data_q;
        case (fc_state_q)
            UFC_FC_IDLE: begin
                if (tx_sel == `UFC_SEL_NONE) begin
                    stop_sent_d = 1'b0;
                end else if (!stop_sent_q && trig_hit) begin
                    send_stop_d = 1'b1;
                    fc_data_d = (tx_sel == `UFC_SEL_SECOND) ?
                        stop_char_second_q : stop_char_first_q;
                    fc_state_d = UFC_FC_FIRST;
                end else if (stop_sent_q && below_low) begin
                    send_stop_d = 1'b0;
                    fc_data_d = (tx_sel == `UFC_SEL_SECOND) ?
                        resume_char_second_q : resume_char_first_q;
                    fc_state_d = UFC_FC_FIRST;
                end
            end
            UFC_FC_FIRST: begin
                if (fc_ready) begin
                    if (tx_sel == `UFC_SEL_BOTH) begin
                        fc_data_d = send_stop_q ? stop_char_second_q : resume_char_second_q;
                        fc_state_d = UFC_FC_SECOND;
                    end else begin
                        stop_sent_d = send_stop_q;
                        fc_state_d = UFC_FC_IDLE;
                    end
                end
            end
            UFC_FC_SECOND: begin
                if (fc_ready) begin
                    stop_sent_d = send_stop_q;
                    fc_state_d = UFC_FC_IDLE;
                end
            end
            default: fc_state_d = UFC_FC_IDLE;
        endcase
    end

    // pins
    always_comb begin
        // flow characters are not held back by cts; only queued data is
        tx_halt_d = (efr_q[`UFC_EFR_ACTS] && cts_n) || sw_halt_q;
        txd_d = txd_raw;
        dtr_n_d = !mcr_q[`UFC_MCR_DTR];
        if (!mcr_q[`UFC_MCR_RTS])
            rts_n_d = 1'b1;
        else if (efr_q[`UFC_EFR_ARTS])
            rts_n_d = rts_block_q;
        else
            rts_n_d = 1'b0;
        int_d = (ier_q[`UFC_IER_RXDATA] && trig_hit) ||
            (ier_q[`UFC_IER_STOP] && stop_flag_q) ||
            ((ier_q[`UFC_IER_RTS] || ier_q[`UFC_IER_CTS]) && hw_flag_q);
        int_oe_n_d = !mcr_q[`UFC_MCR_INTEN];
    end

    // register writes
    always_comb begin
        efr_d = efr_q;
        resume_char_first_d = resume_char_first_q;
        resume_char_second_d = resume_char_second_q;
        stop_char_first_d = stop_char_first_q;
        stop_char_second_d = stop_char_second_q;
        ier_d = ier_q;
        fcr_d = fcr_q;
        mcr_d = mcr_q;
        dld_d = dld_q;
        tx_dll_d = tx_dll_q;
        tx_dlm_d = tx_dlm_q;
        rx_dll_d = rx_dll_q;
        rx_dlm_d = rx_dlm_q;
        if (wr_fire) begin
            case (wb_adr_i)
                `UFC_ADR_EFR: efr_d = wb_dat_i[7:0];
                `UFC_ADR_RES1: resume_char_first_d = wb_dat_i[7:0];
                `UFC_ADR_RES2: resume_char_second_d = wb_dat_i[7:0];
                `UFC_ADR_STP1: stop_char_first_d = wb_dat_i[7:0];
                `UFC_ADR_STP2: stop_char_second_d = wb_dat_i[7:0];
                `UFC_ADR_IER: ier_d = enh ? wb_dat_i[7:0] :
                    ((wb_dat_i[7:0] & ~`UFC_ENH_MASK_IER) | (ier_q & `UFC_ENH_MASK_IER));
                `UFC_ADR_FCR: fcr_d = enh ? wb_dat_i[7:0] :
                    ((wb_dat_i[7:0] & ~`UFC_ENH_MASK_FCR) | (fcr_q & `UFC_ENH_MASK_FCR));
                `UFC_ADR_MCR: mcr_d = enh ? wb_dat_i[7:0] :
                    ((wb_dat_i[7:0] & ~`UFC_ENH_MASK_MCR) | (mcr_q & `UFC_ENH_MASK_MCR));
                `UFC_ADR_DLD: if (enh) dld_d = wb_dat_i[7:0];
                `UFC_ADR_DLL: begin
                    if (dl_tx_wr) tx_dll_d = wb_dat_i[7:0];
                    if (dl_rx_wr) rx_dll_d = wb_dat_i[7:0];
                end
                `UFC_ADR_DLM: begin
                    if (dl_tx_wr) tx_dlm_d = wb_dat_i[7:0];
                    if (dl_rx_wr) rx_dlm_d = wb_dat_i[7:0];
                end
                default: ;
            endcase
        end
    end

    // read data is registered on the request edge, valid while ack is high
    always_comb begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        dat_d = 32'h0;
        case (wb_adr_i)
            `UFC_ADR_EFR: dat_d[7:0] = efr_q;
            `UFC_ADR_RES1: dat_d[7:0] = resume_char_first_q;
            `UFC_ADR_RES2: dat_d[7:0] = resume_char_second_q;
            `UFC_ADR_STP1: dat_d[7:0] = stop_char_first_q;
            `UFC_ADR_STP2: dat_d[7:0] = stop_char_second_q;
            `UFC_ADR_IER: dat_d[7:0] = ier_q;
            `UFC_ADR_ISR: dat_d[7:0] = {2'b00, hw_flag_q, stop_flag_q, 3'b000, !int_q};
            `UFC_ADR_FCR: dat_d[7:0] = fcr_q;
            `UFC_ADR_MCR: dat_d[7:0] = mcr_q;
            `UFC_ADR_DLD: dat_d[7:0] = dld_q;
            `UFC_ADR_DLL: dat_d[7:0] = dld_q[`UFC_DLD_RXRD] ? rx_dll_q : tx_dll_q;
            `UFC_ADR_DLM: dat_d[7:0] = dld_q[`UFC_DLD_RXRD] ? rx_dlm_q : tx_dlm_q;
            `UFC_ADR_STAT: dat_d[7:0] = {rts_block_q, sw_halt_q, stop_sent_q, tx_halt_q,
                                         fc_state_q != UFC_FC_IDLE, 3'b000};
            default: dat_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        tx_dll_q <= tx_dll_d;
        tx_dlm_q <= tx_dlm_d;
        rx_dll_q <= rx_dll_d;
        rx_dlm_q <= rx_dlm_d;
        if (sys_rst) begin
            efr_q <= `UFC_RST_BYTE;
            resume_char_first_q <= `UFC_RST_BYTE;
            resume_char_second_q <= `UFC_RST_BYTE;
            stop_char_first_q <= `UFC_RST_BYTE;
            stop_char_second_q <= `UFC_RST_BYTE;
            ier_q <= `UFC_RST_BYTE;
            fcr_q <= `UFC_RST_BYTE;
            mcr_q <= `UFC_RST_BYTE;
            dld_q <= `UFC_RST_BYTE;
            stop_flag_q <= 1'b0;
            hw_flag_q <= 1'b0;
            sw_halt_q <= 1'b0;
            prev_stop1_q <= 1'b0;
            prev_res1_q <= 1'b0;
            rts_block_q <= 1'b0;
            prev_cts_q <= 1'b1;
            rx_store_q <= 1'b0;
            rx_store_data_q <= `UFC_RST_BYTE;
            fc_state_q <= UFC_FC_IDLE;
            stop_sent_q <= 1'b0;
            send_stop_q <= 1'b0;
            fc_data_q <= `UFC_RST_BYTE;
            tx_halt_q <= 1'b0;
            txd_q <= 1'b1;
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            int_q <= 1'b0;
            int_oe_n_q <= 1'b1;
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            efr_q <= efr_d;
            resume_char_first_q <= resume_char_first_d;
            resume_char_second_q <= resume_char_second_d;
            stop_char_first_q <= stop_char_first_d;
            stop_char_second_q <= stop_char_second_d;
            ier_q <= ier_d;
            fcr_q <= fcr_d;
            mcr_q <= mcr_d;
            dld_q <= dld_d;
            stop_flag_q <= stop_flag_d;
            hw_flag_q <= hw_flag_d;
            sw_halt_q <= sw_halt_d;
            prev_stop1_q <= prev_stop1_d;
            prev_res1_q <= prev_res1_d;
            rts_block_q <= rts_block_d;
            prev_cts_q <= prev_cts_d;
            rx_store_q <= rx_store_d;
            rx_store_data_q <= rx_store_data_d;
            fc_state_q <= fc_state_d;
            stop_sent_q <= stop_sent_d;
            send_stop_q <= send_stop_d;
            fc_data_q <= fc_data_d;
            tx_halt_q <= tx_halt_d;
            txd_q <= txd_d;
            rts_n_q <= rts_n_d;
            dtr_n_q <= dtr_n_d;
            int_q <= int_d;
            int_oe_n_q <= int_oe_n_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign rx_store = rx_store_q;
    assign rx_store_data = rx_store_data_q;
    assign tx_halt = tx_halt_q;
    assign fc_valid = (fc_state_q != UFC_FC_IDLE);
    assign fc_data = fc_data_q;
    assign txd_o = txd_q;
    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;
    assign int_o = int_q;
    assign int_oe_n = int_oe_n_q;
    assign addr_match_char = stop_char_second_q;
    assign tx_divisor = {tx_dlm_q, tx_dll_q};
    assign rx_divisor = {rx_dlm_q, rx_dll_q};
    assign frac_cfg = dld_q[`UFC_DLD_FRAC];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_seq_first;
        rx_valid && mode_seq && hit[2];
    endsequence
    sequence s_seq_second;
        rx_valid && mode_seq && hit[3] && !hit[2];
    endsequence
    sequence s_fill_single;
        fc_state_q == UFC_FC_IDLE && tx_sel == `UFC_SEL_FIRST && trig_hit && !stop_sent_q;
    endsequence

    a_reset_pins: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> txd_o && rts_n && dtr_n && int_oe_n && !tx_halt)
        else $error("pins not in reset state");
    a_cts_halt: assert property (efr_q[`UFC_EFR_ACTS] && cts_n |=> tx_halt)
        else $error("transmit not halted by cts");
    a_cts_resume: assert property (efr_q[`UFC_EFR_ACTS] && !cts_n && !sw_halt_q |=> !tx_halt)
        else $error("transmit not resumed");
    a_second_swallow: assert property (rx_valid && rx_sel == `UFC_SEL_SECOND && hit[3] && enh
        && efr_q[`UFC_EFR_SPEC] |=> !rx_store && stop_flag_q && sw_halt_q)
        else $error("second stop character mishandled");
    a_special_store: assert property (rx_valid && rx_sel == `UFC_SEL_FIRST && hit[3] && !hit[2]
        && !hit[0] && enh && efr_q[`UFC_EFR_SPEC]
        |=> rx_store && rx_store_data == $past(rx_data) && stop_flag_q)
        else $error("special character not stored");
    a_enh_locked: assert property (wr_fire && wb_adr_i == `UFC_ADR_IER && !enh
        |=> ier_q[`UFC_IER_ENH] == $past(ier_q[`UFC_IER_ENH]))
        else $error("locked enhanced bits changed");
    // the pair need not be on adjacent cycles; idle cycles keep the first match
    a_seq_stop: assert property (s_seq_first ##1 (!rx_valid)[*2] ##1 s_seq_second
        |=> sw_halt_q)
        else $error("stop sequence not recognized");
    a_either_stop: assert property (mode_either && rx_valid && hit[3] |=> sw_halt_q && !rx_store)
        else $error("either-character stop missed");
    a_fc_stop_send: assert property (s_fill_single |=> fc_valid && fc_data == $past(stop_char_first_q))
        else $error("stop character not offered");
    a_auto_rts_high: assert property (efr_q[`UFC_EFR_ARTS] && mcr_q[`UFC_MCR_RTS] && above_up
        && $stable(efr_q) && $stable(mcr_q) ##1 $stable(efr_q) && $stable(mcr_q) |=> rts_n)
        else $error("rts not raised above upper level");
    a_rts_manual: assert property (!efr_q[`UFC_EFR_ARTS] && mcr_q[`UFC_MCR_RTS] ##1
        !efr_q[`UFC_EFR_ARTS] && mcr_q[`UFC_MCR_RTS] |-> !rts_n)
        else $error("rts does not follow its control bit");
endmodule : ufc_core

/* dv/ufc_peer.sv */
/* remote peer's transmitter side: takes flow characters off the core.
   assumes: fc_valid and fc_data hold until taken; slow delays the take. */
`timescale 1ns/1ps
module ufc_peer (
    input wire logic clk,
    input wire logic fc_valid,
    input wire logic [7:0] fc_data,
    input wire logic slow,
    output logic fc_ready,
    output logic [7:0] last_char
);
    int n = 0;
    initial fc_ready = 1'b0;
    initial last_char = 8'h00;
    // a slow peer leaves the character pending a few cycles
    always @(posedge clk) begin
        n <= fc_valid ? n + 1 : 0;
        fc_ready <= fc_valid && !fc_ready && (!slow || n > 2);
        if (fc_valid && fc_ready) last_char <= fc_data;
    end
endmodule : ufc_peer

/* dv/ufc_core_test.sv */
/* bench of ufc_core: register model, flow characters, modem pins, reset.
   assumes: ufc_map.svh, ufc_pkg, ufc_core and ufc_peer compiled first. */
`timescale 1ns/1ps
`include "ufc_map.svh"
module ufc_core_test;
    logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, we = 1'b0, rv = 1'b0, cts_n = 1'b0;
    logic txd = 1'b1, slow = 1'b0, ack, st, halt, fv, fr, rts_n, dtr_n, txd_o, ioe, io;
    logic [3:0] sel = 4'h1;
    logic [7:0] adr = 8'h00, rc = 8'h00, sd, fd, lc, am, q;
    logic [5:0] lvl = 6'd0, fcf;
    logic [31:0] di = 32'h0, dout;
    logic [15:0] txv, rxv;
    logic [7:0] ch [4];
    int mdl [int];
    int miscompares = 0, n_tests = 0;
    always #50 clk = ~clk;
    always @(posedge clk) txd <= 1'($urandom);
    ufc_core uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack),
        .rx_valid(rv), .rx_data(rc), .rx_level(lvl), .rx_store(st), .rx_store_data(sd),
        .cts_n(cts_n), .tx_halt(halt), .fc_valid(fv), .fc_ready(fr), .fc_data(fd),
        .txd_raw(txd), .txd_o(txd_o), .rts_n(rts_n), .dtr_n(dtr_n), .int_o(io), .int_oe_n(ioe),
        .addr_match_char(am), .tx_divisor(txv), .rx_divisor(rxv), .frac_cfg(fcf));
    ufc_peer peer (.clk(clk), .fc_valid(fv), .fc_data(fd), .slow(slow), .fc_ready(fr),
        .last_char(lc));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        di <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dout[7:0];
        req <= 1'b0;
        if (n == 20) miscompares++;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
        if (a == `UFC_ADR_IER && !mdl[0][`UFC_EFR_ENH])
            mdl[a] = (mdl[a] & 'hf0) | (d & 'h0f);
        else if (a < 8'h30)
            mdl[a] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 8'h00);
        chk("reg", 16'(mdl.exists(a) ? mdl[a] : 0), {8'h0, q});
    endtask : rd
    // divisor latch survives the reset pin, so the model keeps it too
    task automatic rst;
        int dl = mdl.exists(8'h28) ? mdl[8'h28] : 1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        // txd_o copies a random line once out of reset, so look while reset holds
        chk("pins", 16'h000f, {12'h0, txd_o, rts_n, dtr_n, ioe});
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++) mdl[4 * i] = 0;
        mdl[8'h28] = dl;
    endtask : rst
    task automatic rx(input logic [7:0] c, input logic s);
        @(posedge clk);
        rv <= 1'b1;
        rc <= c;
        @(posedge clk);
        rv <= 1'b0;
        @(posedge clk);
        chk("rx_store", s, st);
        if (s) chk("rx_store_data", c, sd);
    endtask : rx
    task automatic hlt(input logic e);
        repeat (3) @(posedge clk);
        chk("tx_halt", e, halt);
    endtask : hlt
    task automatic fcw(input logic [7:0] c);
        for (int n = 0; n < 30 && lc !== c; n++) @(posedge clk);
        chk("flow char", c, lc);
    endtask : fcw
    task automatic enhanced_feature_ctrl(input logic [7:0] v);
        wr(`UFC_ADR_EFR, 8'h10);
        wr(`UFC_ADR_EFR, v);
    endtask : enhanced_feature_ctrl
    initial begin
        void'($urandom(32));
        rst();
        for (int i = 0; i < 12; i++) if (i != 6) rd(8'(4 * i));
        chk("rx_div", 16'h0001, rxv);
        for (int i = 0; i < 4; i++) begin
            ch[i] = 8'h10 + 8'(32 * i) + 8'($urandom_range(0, 15));
            wr(8'(4 * i + 4), ch[i]);
            rd(8'(4 * i + 4));
        end
        chk("match", ch[3], am);
        wr(8'h40, 8'hff);
        rd(8'h40);
        sel <= 4'h0;
        bus(`UFC_ADR_RES1, 1'b1, 8'hee);
        sel <= 4'h1;
        rd(`UFC_ADR_RES1);
        for (int i = 0; i < 2; i++) begin
            wr(`UFC_ADR_EFR, 8'(16 * i));
            wr(`UFC_ADR_IER, 8'hff);
            rd(`UFC_ADR_IER);
        end
        for (int m = 0; m < 3; m++) begin
            enhanced_feature_ctrl(m == 0 ? 8'h12 : m == 1 ? 8'h11 : 8'h1b);
            rx(ch[m == 0 ? 2 : 3], 1'b0);
            hlt(1'b1);
            rx(ch[m == 1], 1'b0);
            hlt(1'b0);
        end
        enhanced_feature_ctrl(8'h1f);
        rx(ch[2], 1'b1);
        rx(ch[3], 1'b0);
        hlt(1'b1);
        enhanced_feature_ctrl(8'h32);
        bus(`UFC_ADR_ISR, 1'b0, 8'h00);
        rx(ch[3], 1'b1);
        hlt(1'b0);
        bus(`UFC_ADR_ISR, 1'b0, 8'h00);
        chk("isr special", 1'b1, q[4]);
        enhanced_feature_ctrl(8'h31);
        chk("int_o", 1'b0, io);
        rx(ch[3], 1'b0);
        hlt(1'b1);
        chk("int_o", 1'b1, io);
        rx(ch[1], 1'b0);
        enhanced_feature_ctrl(8'h90);
        cts_n <= 1'b1;
        hlt(1'b1);
        cts_n <= 1'b0;
        hlt(1'b0);
        enhanced_feature_ctrl(8'h10);
        wr(`UFC_ADR_MCR, 8'h0b);
        repeat (2) @(posedge clk);
        chk("rts dtr oe", 16'h0, {rts_n, dtr_n, ioe});
        enhanced_feature_ctrl(8'h50);
        lvl <= 6'($urandom_range(16, 32));
        repeat (4) @(posedge clk);
        chk("rts_n", 1'b1, rts_n);
        lvl <= 6'd3;
        repeat (4) @(posedge clk);
        chk("rts_n", 1'b0, rts_n);
        for (int m = 0; m < 3; m++) begin
            enhanced_feature_ctrl(m == 0 ? 8'h18 : m == 1 ? 8'h14 : 8'h1c);
            slow <= 1'b1;
            lvl <= 6'd8;
            fcw(ch[m == 0 ? 2 : 3]);
            slow <= 1'b0;
            lvl <= 6'd0;
            fcw(ch[m == 0 ? 0 : 1]);
        end
        wr(`UFC_ADR_DLD, 8'h05);
        wr(`UFC_ADR_DLL, 8'h5a);
        chk("frac", 16'h0005, {10'h0, fcf});
        rst();
        chk("frac", 16'h0000, {10'h0, fcf});
        chk("tx_div", 16'h005a, txv);
        chk("rx_div", 16'h005a, rxv);
        rd(`UFC_ADR_DLL);
        rd(`UFC_ADR_IER);
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule : ufc_core_test
